// *** shared/mmt_pkg.sv ***
// Constants and bus carrier types for the multimode timer channels
//
// Overview of operation
// - Channels stay idle until their start bit is set
// - Live count read; reload coincident read gives ones
// - Counter written while stopped reads back written value
// - A event reads ones on underflow, zeros on overflow
// - One-shot stop: reload, output low, late request
// - One-shot output waits for count source tick
// - Entering one-shot from timer/event sets request
// - Trigger while counting reloads after one count; code reloads on the first tick at or after it, without a countdown
// - Entering PWM from timer/event sets request
// - PWM stop: high output drops and raises request
// - Measurement requests on edge and overflow
// - Overflow flag clears on mode write, next tick
// - First measured edge loads reload, no request
// - Counter undefined at measurement start
// - Width mode measures consecutive widths, no level
`default_nettype none
package mmt_pkg;
   localparam int NUM_A = 5;                  // A-type channels
   localparam int NUM_B = 6;                  // B-type channels
   localparam int NUM_CH = NUM_A + NUM_B;     // All channels
   localparam int CW = 16;                    // Counter width
   localparam int AW = 8;                     // Byte address width
   localparam int DW = 32;                    // Bus data width
   localparam int PSW = 5;                    // Prescaler width
   // Register byte offsets
   localparam logic [7:0] OFS_START = 8'h00;  // count_start_flags
   localparam logic [7:0] OFS_IRQ   = 8'h04;  // interrupt_request_flag, W1C
   localparam logic [7:0] OFS_TRIG  = 8'h08;  // oneshot_start_flags, W1 pulse
   localparam logic [7:0] OFS_UDF   = 8'h0C;  // updown_flags
   localparam logic [7:0] OFS_AMODE = 8'h10;  // a_channel_mode_reg array
   localparam logic [7:0] OFS_BMODE = 8'h30;  // b_channel_mode_reg array
   localparam logic [7:0] OFS_ACNT  = 8'h50;  // a_channel_counter array
   localparam logic [7:0] OFS_BCNT  = 8'h70;  // b_channel_counter array
   // Mode register fields
   localparam int MD_OP  = 0;                 // operation_mode_bit1:0
   localparam int MD_F0  = 2;                 // mode_function_bit0
   localparam int MD_OVF = 3;                 // overflow_flag
   localparam int MD_RSV = 4;                 // reserved_measure_bit
   localparam int MD_F1  = 5;                 // mode_function_bit1
   localparam int MD_SRC = 6;                 // count_source_sel1:0
   localparam logic [7:0] MODE_RST = 8'h00;   // Mode reset value
   // Operation modes
   localparam logic [1:0] OP_TIMER = 2'h0;
   localparam logic [1:0] OP_EVENT = 2'h1;
   localparam logic [1:0] OP_ONESHOT = 2'h2;  // A: one-shot, B: measure
   localparam logic [1:0] OP_PWM = 2'h3;
   // Count source selections
   localparam logic [1:0] SRC_MID = 2'h1;     // Divide by 8
   localparam logic [1:0] SRC_SLOW = 2'h2;    // Divide by 32
   localparam logic [1:0] SRC_EXT = 2'h3;     // Input pin rising edge
   localparam logic [CW-1:0] CNT_ONES = 16'hFFFF;
   localparam logic [CW-1:0] CNT_ZERO = 16'h0000;
   // Avalon-MM request from the master
   typedef struct packed {
      logic          read;
      logic          write;
      logic [AW-1:0] address;
      logic [DW-1:0] writedata;
   } mmt_bus_req_type;
endpackage : mmt_pkg
`default_nettype wire

// *** design/mmt_timer.sv ***
// Multimode timer channels with Avalon-MM register slave
`default_nettype none
module mmt_timer (
   input  wire logic                          ref_clk,
   input  wire logic                          srst,
   input  wire mmt_pkg::mmt_bus_req_type      bus_req,
   output logic [mmt_pkg::DW-1:0]             readdata,
   output logic                               waitrequest,
   input  wire logic [mmt_pkg::NUM_A-1:0]     a_channel_input_pin,
   input  wire logic [mmt_pkg::NUM_B-1:0]     b_channel_input_pin,
   output logic [mmt_pkg::NUM_A-1:0]          a_channel_output_pin,
   output logic [mmt_pkg::NUM_CH-1:0]         interrupt_request_flag
);
   localparam int NA = mmt_pkg::NUM_A;
   localparam int NB = mmt_pkg::NUM_B;
   localparam int CW = mmt_pkg::CW;

   // Address within an array of per-channel words
   function automatic logic in_arr(input logic [7:0] a, input logic [7:0] b, input int n);
      in_arr = (a >= b) && (int'(a) < int'(b) + 4 * n) && (a[1:0] == 2'h0);
   endfunction : in_arr

   // Channel index inside an array
   function automatic logic [3:0] arr_idx(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] d;
      d = a - b;
      arr_idx = d[5:2];
   endfunction : arr_idx

   // Internal count source tick from selection
   function automatic logic src_tick(input logic [1:0] s, input logic [4:0] ps, input logic ext);
      case (s)
         mmt_pkg::SRC_MID:  src_tick = (ps[2:0] == 3'h0);
         mmt_pkg::SRC_SLOW: src_tick = (ps == 5'h00);
         mmt_pkg::SRC_EXT:  src_tick = ext;
         default:           src_tick = 1'b1;
      endcase
   endfunction : src_tick

   // Bus handshake
   logic          ack_r;                       // Answer cycle marker
   logic          take_w;                      // Write takes effect
   logic [7:0]    adr;                         // Request address
   logic [31:0]   wd;                          // Request write data
   logic [3:0]    wi;                          // Write channel index
   // Shared control
   logic [mmt_pkg::PSW-1:0] ps_r;              // Free prescaler
   logic [10:0]   run_r;                       // Start bits
   logic [10:0]   irq_r;                       // Request flags
   logic [10:0]   irq_set;                     // Request set events
   logic [4:0]    udf_r;                       // Up-count select
   logic [4:0]    sw_trg;                      // Software trigger pulses
   // A channels
   logic [CW-1:0] a_cnt_r [NA];                // Live counter
   logic [CW-1:0] a_rel_r [NA];                // Reload register
   logic [7:0]    a_mode_r [NA];               // Mode register
   logic [NA-1:0] a_in_r;                      // Input history
   logic [NA-1:0] a_busy_r;                    // One-shot pulse active
   logic [NA-1:0] a_pend_r;                    // Trigger awaits tick
   logic [NA-1:0] a_sirq_r;                    // Delayed stop request
   logic [NA-1:0] a_out_r;                     // Output pin
   logic [NA-1:0] a_edge, a_tick, a_unf, a_ovf, a_stop, a_trg, a_mwr, a_cwr;
   // B channels
   logic [CW-1:0] b_cnt_r [NB];
   logic [CW-1:0] b_rel_r [NB];
   logic [7:0]    b_mode_r [NB];
   logic [NB-1:0] b_in_r;
   logic [NB-1:0] b_ovf_r;                     // Overflow flag
   logic [NB-1:0] b_clr_r;                     // Overflow clear pending
   logic [NB-1:0] b_first_r;                   // First edge not yet seen
   logic [NB-1:0] b_rise, b_tick, b_unf, b_ovf, b_medge, b_mwr, b_cwr, b_start;
   // Read path
   logic [31:0]   rd_val;
   logic          rd_ones, rd_zeros;

   assign adr = bus_req.address;
   assign wd = bus_req.writedata;
   // Index taken from whichever per-channel array holds the address
   assign wi = in_arr(adr, mmt_pkg::OFS_BCNT, NB) ? arr_idx(adr, mmt_pkg::OFS_BCNT)
             : in_arr(adr, mmt_pkg::OFS_ACNT, NA) ? arr_idx(adr, mmt_pkg::OFS_ACNT)
             : in_arr(adr, mmt_pkg::OFS_BMODE, NB) ? arr_idx(adr, mmt_pkg::OFS_BMODE)
             : arr_idx(adr, mmt_pkg::OFS_AMODE);
   assign take_w = bus_req.write && ack_r;
   // One wait state on every access
   assign waitrequest = (bus_req.read || bus_req.write) && !ack_r;
   assign a_channel_output_pin = a_out_r;
   assign interrupt_request_flag = irq_r;

   // Answer marker toggles once per request
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (bus_req.read || bus_req.write) && !ack_r;
      end
   end

   // Read data captured in the wait cycle, stands at answer edge
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         readdata <= 32'h0000_0000;
      end else if (bus_req.read && !ack_r) begin
         readdata <= rd_val;
      end
   end

   // Free running prescaler for internal count sources
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ps_r <= '0;
      end else begin
         ps_r <= ps_r + 5'h01;
      end
   end

   // Per-channel decode and event detection
   always_comb begin
      for (int i = 0; i < NA; i++) begin
         a_mwr[i] = take_w && in_arr(adr, mmt_pkg::OFS_AMODE, NA) && wi == 4'(i);
         a_cwr[i] = take_w && in_arr(adr, mmt_pkg::OFS_ACNT, NA) && wi == 4'(i);
         a_stop[i] = take_w && adr == mmt_pkg::OFS_START && run_r[i] && !wd[i];
         a_edge[i] = a_channel_input_pin[i] && !a_in_r[i];
         a_tick[i] = (a_mode_r[i][1:0] == mmt_pkg::OP_EVENT) ? a_edge[i]
                   : src_tick(a_mode_r[i][7:6], ps_r, a_edge[i]);
         a_trg[i] = sw_trg[i] || (a_mode_r[i][mmt_pkg::MD_F0] && a_edge[i]);
         // Underflow reload; idle one-shot does not count
         a_unf[i] = run_r[i] && a_tick[i] && a_cnt_r[i] == mmt_pkg::CNT_ZERO
                  && !(udf_r[i] && a_mode_r[i][1:0] == mmt_pkg::OP_EVENT)
                  && !(a_mode_r[i][1:0] == mmt_pkg::OP_ONESHOT && !a_busy_r[i]);
         a_ovf[i] = run_r[i] && a_tick[i] && a_cnt_r[i] == mmt_pkg::CNT_ONES
                  && udf_r[i] && a_mode_r[i][1:0] == mmt_pkg::OP_EVENT;
      end
      for (int j = 0; j < NB; j++) begin
         b_mwr[j] = take_w && in_arr(adr, mmt_pkg::OFS_BMODE, NB) && wi == 4'(j);
         b_cwr[j] = take_w && in_arr(adr, mmt_pkg::OFS_BCNT, NB) && wi == 4'(j);
         b_start[j] = take_w && adr == mmt_pkg::OFS_START && !run_r[NA+j] && wd[NA+j];
         b_rise[j] = b_channel_input_pin[j] && !b_in_r[j];
         b_tick[j] = (b_mode_r[j][1:0] == mmt_pkg::OP_EVENT) ? b_rise[j]
                   : src_tick(b_mode_r[j][7:6], ps_r, b_rise[j]);
         // Period: rising edges; width: every edge, level not kept
         b_medge[j] = run_r[NA+j] && b_mode_r[j][1:0] == mmt_pkg::OP_ONESHOT
                    && (b_mode_r[j][mmt_pkg::MD_F1] ? (b_channel_input_pin[j] != b_in_r[j]) : b_rise[j]);
         b_ovf[j] = run_r[NA+j] && b_tick[j] && b_mode_r[j][1:0] == mmt_pkg::OP_ONESHOT
                  && b_cnt_r[j] == mmt_pkg::CNT_ONES;
         b_unf[j] = run_r[NA+j] && b_tick[j] && b_mode_r[j][1:0] != mmt_pkg::OP_ONESHOT
                  && b_cnt_r[j] == mmt_pkg::CNT_ZERO;
      end
   end

   // Software trigger pulses
   assign sw_trg = (take_w && adr == mmt_pkg::OFS_TRIG) ? wd[4:0] : 5'h00;

   // Start bits and up-count selects
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         run_r <= 11'h000;
         udf_r <= 5'h00;
      end else if (take_w && adr == mmt_pkg::OFS_START) begin
         run_r <= wd[10:0];
      end else if (take_w && adr == mmt_pkg::OFS_UDF) begin
         udf_r <= wd[4:0];
      end
   end

   // Request set events for every channel
   always_comb begin
      for (int i = 0; i < NA; i++) begin
         logic [1:0] op;
         op = a_mode_r[i][1:0];
         irq_set[i] = a_sirq_r[i];
         // Mode moves into one-shot or PWM from timer or event
         if (a_mwr[i] && !op[1] && wd[1]) begin
            irq_set[i] = 1'b1;
         end
         if (a_unf[i] || a_ovf[i]) begin
            irq_set[i] = irq_set[i] || op != mmt_pkg::OP_PWM || a_out_r[i];
         end
         if (a_stop[i] && op == mmt_pkg::OP_PWM && a_out_r[i]) begin
            irq_set[i] = 1'b1;
         end
      end
      for (int j = 0; j < NB; j++) begin
         irq_set[NA+j] = b_unf[j] || b_ovf[j] || (b_medge[j] && !b_first_r[j]);
      end
   end

   // Request flags: set wins over a write-one clear
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         irq_r <= 11'h000;
      end else begin
         irq_r <= (irq_r & ~((take_w && adr == mmt_pkg::OFS_IRQ) ? wd[10:0] : 11'h000)) | irq_set;
      end
   end

   // A channels: timer, event, one-shot and PWM
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         a_in_r <= '0;
         a_busy_r <= '0;
         a_pend_r <= '0;
         a_sirq_r <= '0;
         a_out_r <= '0;
         for (int i = 0; i < NA; i++) begin
            a_cnt_r[i] <= mmt_pkg::CNT_ZERO;
            a_rel_r[i] <= mmt_pkg::CNT_ZERO;
            a_mode_r[i] <= mmt_pkg::MODE_RST;
         end
      end else begin
         a_in_r <= a_channel_input_pin;
         for (int i = 0; i < NA; i++) begin
            a_sirq_r[i] <= a_stop[i] && a_mode_r[i][1:0] == mmt_pkg::OP_ONESHOT;
            if (a_mwr[i]) begin
               a_mode_r[i] <= wd[7:0];
            end
            if (a_cwr[i]) begin
               a_rel_r[i] <= wd[CW-1:0];
            end
            if (a_stop[i]) begin
               // Stop: one-shot reloads, output falls
               if (a_mode_r[i][1:0] == mmt_pkg::OP_ONESHOT) begin
                  a_cnt_r[i] <= a_rel_r[i];
               end
               a_out_r[i] <= 1'b0;
               a_busy_r[i] <= 1'b0;
               a_pend_r[i] <= 1'b0;
            end else if (!run_r[i]) begin
               if (a_cwr[i]) begin
                  a_cnt_r[i] <= wd[CW-1:0];
               end
            end else begin
               case (a_mode_r[i][1:0])
                  mmt_pkg::OP_ONESHOT: begin
                     if (a_tick[i] && (a_pend_r[i] || a_trg[i])) begin
                        // Trigger acts on the count source tick
                        a_busy_r[i] <= 1'b1;
                        a_out_r[i] <= 1'b1;
                        a_cnt_r[i] <= a_rel_r[i];
                        a_pend_r[i] <= 1'b0;
                     end else if (a_trg[i]) begin
                        a_pend_r[i] <= 1'b1;
                     end else if (a_unf[i]) begin
                        a_busy_r[i] <= 1'b0;
                        a_out_r[i] <= 1'b0;
                        a_cnt_r[i] <= a_rel_r[i];
                     end else if (a_tick[i] && a_busy_r[i]) begin
                        a_cnt_r[i] <= a_cnt_r[i] - 16'h0001;
                     end
                  end
                  mmt_pkg::OP_PWM: begin
                     if (a_unf[i]) begin
                        // High phase lasts reload, low the rest
                        a_out_r[i] <= !a_out_r[i];
                        a_cnt_r[i] <= a_out_r[i] ? mmt_pkg::CNT_ONES - a_rel_r[i] : a_rel_r[i];
                     end else if (a_tick[i]) begin
                        a_cnt_r[i] <= a_cnt_r[i] - 16'h0001;
                     end
                  end
                  default: begin
                     if (a_unf[i] || a_ovf[i]) begin
                        a_cnt_r[i] <= a_rel_r[i];
                     end else if (a_tick[i]) begin
                        a_cnt_r[i] <= udf_r[i] && a_mode_r[i][1:0] == mmt_pkg::OP_EVENT
                                    ? a_cnt_r[i] + 16'h0001 : a_cnt_r[i] - 16'h0001;
                     end
                  end
               endcase
            end
         end
      end
   end

   // B channels: timer, event and pulse measurement
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         b_in_r <= '0;
         b_ovf_r <= '0;
         b_clr_r <= '0;
         b_first_r <= '0;
         for (int j = 0; j < NB; j++) begin
            b_cnt_r[j] <= mmt_pkg::CNT_ZERO;
            b_rel_r[j] <= mmt_pkg::CNT_ZERO;
            b_mode_r[j] <= mmt_pkg::MODE_RST;
         end
      end else begin
         b_in_r <= b_channel_input_pin;
         for (int j = 0; j < NB; j++) begin
            if (b_start[j]) begin
               b_first_r[j] <= 1'b1;
            end
            if (b_mwr[j]) begin
               b_mode_r[j] <= wd[7:0];
            end
            // Overflow flag: set wins, clear waits for a counted tick
            if (b_ovf[j]) begin
               b_ovf_r[j] <= 1'b1;
               b_clr_r[j] <= 1'b0;
            end else if (b_clr_r[j] && b_tick[j]) begin
               b_ovf_r[j] <= 1'b0;
               b_clr_r[j] <= 1'b0;
            end else if (b_mwr[j] && run_r[NA+j] && b_ovf_r[j]) begin
               b_clr_r[j] <= 1'b1;
            end
            if (b_cwr[j]) begin
               b_rel_r[j] <= wd[CW-1:0];
            end
            if (!run_r[NA+j]) begin
               if (b_cwr[j]) begin
                  b_cnt_r[j] <= wd[CW-1:0];
               end
            end else if (b_mode_r[j][1:0] == mmt_pkg::OP_ONESHOT) begin
               // Count held from before start is used as is
               if (b_medge[j]) begin
                  b_rel_r[j] <= b_cnt_r[j];
                  b_cnt_r[j] <= mmt_pkg::CNT_ZERO;
                  b_first_r[j] <= 1'b0;
               end else if (b_tick[j]) begin
                  b_cnt_r[j] <= b_cnt_r[j] + 16'h0001;
               end
            end else if (b_unf[j]) begin
               b_cnt_r[j] <= b_rel_r[j];
            end else if (b_tick[j]) begin
               b_cnt_r[j] <= b_cnt_r[j] - 16'h0001;
            end
         end
      end
   end

   // Read multiplexer with reload coincidence values
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_ones = 1'b0;
      rd_zeros = 1'b0;
      if (adr == mmt_pkg::OFS_START) begin
         rd_val[10:0] = run_r;
      end else if (adr == mmt_pkg::OFS_IRQ) begin
         rd_val[10:0] = irq_r;
      end else if (adr == mmt_pkg::OFS_UDF) begin
         rd_val[4:0] = udf_r;
      end
      for (int i = 0; i < NA; i++) begin
         if (wi == 4'(i) && in_arr(adr, mmt_pkg::OFS_AMODE, NA)) begin
            rd_val[7:0] = a_mode_r[i];
         end
         if (wi == 4'(i) && in_arr(adr, mmt_pkg::OFS_ACNT, NA)) begin
            rd_ones = a_unf[i];
            rd_zeros = a_ovf[i];
            rd_val[CW-1:0] = rd_ones ? mmt_pkg::CNT_ONES : rd_zeros ? mmt_pkg::CNT_ZERO : a_cnt_r[i];
         end
      end
      for (int j = 0; j < NB; j++) begin
         if (wi == 4'(j) && in_arr(adr, mmt_pkg::OFS_BMODE, NB)) begin
            rd_val[7:0] = b_mode_r[j];
            rd_val[mmt_pkg::MD_OVF] = b_ovf_r[j];
         end
         if (wi == 4'(j) && in_arr(adr, mmt_pkg::OFS_BCNT, NB)) begin
            rd_ones = b_unf[j];
            rd_val[CW-1:0] = rd_ones ? mmt_pkg::CNT_ONES : b_cnt_r[j];
         end
      end
   end

   // Checks on the bus answer, counter reads and channels A0 and B0
   property p_bus_answer;
      @(posedge ref_clk) disable iff (srst) (bus_req.read || bus_req.write) |-> ##[0:1] !waitrequest;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("Bus answer late");
   property p_idle;
      @(posedge ref_clk) disable iff (srst) !run_r[0] && !a_cwr[0] |=> $stable(a_cnt_r[0]);
   endproperty
   a_idle: assert property (p_idle) else $error("Stopped counter moved");
   property p_rd_ones;
      @(posedge ref_clk) disable iff (srst) bus_req.read && !ack_r && rd_ones |=> readdata == 32'h0000_FFFF;
   endproperty
   a_rd_ones: assert property (p_rd_ones) else $error("Reload read not ones");
   property p_rd_zeros;
      @(posedge ref_clk) disable iff (srst) bus_req.read && !ack_r && rd_zeros |=> readdata == 32'h0000_0000;
   endproperty
   a_rd_zeros: assert property (p_rd_zeros) else $error("Overflow read not zero");
   property p_wr_stopped;
      @(posedge ref_clk) disable iff (srst) a_cwr[0] && !run_r[0] |=> a_cnt_r[0] == $past(wd[15:0]);
   endproperty
   a_wr_stopped: assert property (p_wr_stopped) else $error("Written count lost");
   property p_os_stop;
      @(posedge ref_clk) disable iff (srst)
         a_stop[0] && a_mode_r[0][1:0] == mmt_pkg::OP_ONESHOT |=> !a_out_r[0] ##1 irq_r[0];
   endproperty
   a_os_stop: assert property (p_os_stop) else $error("One-shot stop wrong");
   property p_mode_irq;
      @(posedge ref_clk) disable iff (srst) a_mwr[0] && !a_mode_r[0][1] && wd[1] |=> irq_r[0];
   endproperty
   a_mode_irq: assert property (p_mode_irq) else $error("Mode entry no request");
   property p_retrig;
      @(posedge ref_clk) disable iff (srst)
         run_r[0] && !a_stop[0] && a_mode_r[0][1:0] == mmt_pkg::OP_ONESHOT && a_tick[0]
         && (a_pend_r[0] || a_trg[0])
         |=> a_cnt_r[0] == $past(a_rel_r[0]) && a_out_r[0];
   endproperty
   a_retrig: assert property (p_retrig) else $error("Retrigger no reload");
   property p_pwm_stop;
      @(posedge ref_clk) disable iff (srst)
         a_stop[0] && a_mode_r[0][1:0] == mmt_pkg::OP_PWM && a_out_r[0] |=> !a_out_r[0] && irq_r[0];
   endproperty
   a_pwm_stop: assert property (p_pwm_stop) else $error("PWM stop wrong");
   property p_b_ovf;
      @(posedge ref_clk) disable iff (srst) b_ovf[0] |=> b_ovf_r[0] && irq_r[NA];
   endproperty
   a_b_ovf: assert property (p_b_ovf) else $error("Overflow not flagged");
   property p_b_clr;
      @(posedge ref_clk) disable iff (srst) b_clr_r[0] && b_tick[0] && !b_ovf[0] |=> !b_ovf_r[0];
   endproperty
   a_b_clr: assert property (p_b_clr) else $error("Overflow not cleared");
   property p_b_first;
      @(posedge ref_clk) disable iff (srst)
         b_medge[0] && b_first_r[0] && !b_ovf[0] && !irq_r[NA] |=> !irq_r[NA];
   endproperty
   a_b_first: assert property (p_b_first) else $error("First edge raised request");
   c_os_fire: cover property (@(posedge ref_clk) disable iff (srst) a_out_r[0] ##1 !a_out_r[0]);
   c_b_edge: cover property (@(posedge ref_clk) disable iff (srst) b_medge[0] && !b_first_r[0]);
   c_b_ovf: cover property (@(posedge ref_clk) disable iff (srst) b_ovf[0]);
endmodule : mmt_timer
`default_nettype wire

// *** sim/mmt_pin_model.sv ***
// Far-side pulse source for the measured and trigger input pins
`default_nettype none
module mmt_pin_model (
   input  wire logic       ref_clk,
   input  wire logic [5:0] fire,
   input  wire logic [4:0] a_fire,
   output logic [4:0]      a_pin,
   output logic [5:0]      b_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // Each fire bit gives one rising edge, one cycle high
   always_ff @(posedge ref_clk) begin
      b_pin <= fire;
      a_pin <= a_fire;
   end
endmodule : mmt_pin_model
`default_nettype wire

// *** sim/mmt_timer_bench.sv ***
// Self-checking bench for the multimode timer channels
`default_nettype none
module mmt_timer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0, srst = 1'b1;
   mmt_pkg::mmt_bus_req_type req = '0;
   logic [31:0] rdata, rd;
   logic waitrequest;
   logic [4:0] a_in, a_out, a_fire = '0;
   logic [5:0] b_in, fire = '0;
   logic [10:0] irq;
   int failures = 0, cmp_count = 0;
   mmt_timer dut_u (.ref_clk(ref_clk), .srst(srst), .bus_req(req), .readdata(rdata), .waitrequest(waitrequest),
      .a_channel_input_pin(a_in), .b_channel_input_pin(b_in), .a_channel_output_pin(a_out),
      .interrupt_request_flag(irq));
   mmt_pin_model pin_u (.ref_clk(ref_clk), .fire(fire), .a_fire(a_fire), .a_pin(a_in), .b_pin(b_in));
   // Clock at 100 ns period
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   // Compare and count
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // One Avalon access, held until waitrequest low
   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      req.read <= ~w;
      req.write <= w;
      req.address <= a;
      req.writedata <= wd;
      do begin
         @(posedge ref_clk);
      end while (waitrequest !== 1'b0);
      rd = rdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
      @(posedge ref_clk);
   endtask : bus
   task tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick
   task test_done;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   // Idle after reset, stopped counter holds written value
   task t_idle;
      bus(0, 8'h50, 0);
      chk("cnt0", 0, rd);
      bus(1, 8'h50, 32'h1234);
      tick(20);
      bus(0, 8'h50, 0);
      chk("held", 32'h1234, rd);
      bus(1, 8'h00, 32'h1);
      tick(20);
      bus(0, 8'h50, 0);
      chk("live", 1, rd[15:0] < 16'h1234);
      bus(1, 8'h00, 0);
   endtask : t_idle
   // One-shot entry, trigger, stop
   task t_oneshot;
      bus(1, 8'h04, 32'h7FF);
      bus(1, 8'h10, 32'h2);
      tick(2);
      chk("os_irq", 1, irq[0]);
      bus(1, 8'h04, 32'h7FF);
      bus(1, 8'h50, 32'h40);
      bus(1, 8'h00, 32'h1);
      bus(1, 8'h08, 32'h1);
      tick(3);
      chk("os_out", 1, a_out[0]);
      bus(1, 8'h00, 0);
      tick(3);
      chk("os_stop", 2'b01, {a_out[0], irq[0]});
   endtask : t_oneshot
   // PWM entry from timer, stop while high
   task t_pwm;
      int n;
      bus(1, 8'h10, 32'h0);
      bus(1, 8'h04, 32'h7FF);
      bus(1, 8'h10, 32'h3);
      tick(2);
      chk("pwm_irq", 1, irq[0]);
      bus(1, 8'h04, 32'h7FF);
      bus(1, 8'h50, 32'h20);
      bus(1, 8'h00, 32'h1);
      n = 0;
      while (a_out[0] !== 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
      chk("pwm_high", 1, a_out[0]);
      bus(1, 8'h00, 0);
      tick(3);
      chk("pwm_stop", 2'b01, {a_out[0], irq[0]});
   endtask : t_pwm
   // Event counter on A0 counts input pin rising edges down
   task t_event;
      bus(1, 8'h10, 32'h1);
      bus(1, 8'h50, 32'h5);
      bus(1, 8'h00, 32'h1);
      a_fire <= 5'h01;
      tick(1);
      a_fire <= 5'h00;
      tick(1);
      a_fire <= 5'h01;
      tick(1);
      a_fire <= 5'h00;
      tick(3);
      bus(0, 8'h50, 0);
      chk("evt_cnt", 3, rd);
      bus(1, 8'h00, 0);
   endtask : t_event
   // Period measurement on B0: first edge silent, second requests
   task t_meas;
      bus(1, 8'h30, 32'h2);
      bus(1, 8'h70, 32'hFFF0);
      bus(1, 8'h00, 32'h20);
      bus(1, 8'h04, 32'h7FF);
      tick(20);
      chk("ovf_irq", 1, irq[5]);
      bus(0, 8'h30, 0);
      chk("ovf_flag", 1, rd[3]);
      bus(1, 8'h30, 32'h2);
      bus(0, 8'h30, 0);
      chk("ovf_clr", 0, rd[3]);
      bus(1, 8'h04, 32'h7FF);
      fire <= 6'h01;
      tick(1);
      fire <= 6'h00;
      tick(3);
      chk("first_edge", 0, irq[5]);
      tick(20);
      fire <= 6'h01;
      tick(1);
      fire <= 6'h00;
      tick(3);
      chk("edge_irq", 1, irq[5]);
      bus(0, 8'h30, 0);
      chk("no_ovf", 0, rd[3]);
      bus(1, 8'h00, 0);
   endtask : t_meas
   // Main sequence
   initial begin
      tick(16);
      srst <= 1'b0;
      chk("out_rst", 0, {a_out, irq});
      t_idle;
      t_oneshot;
      t_pwm;
      t_event;
      t_meas;
      test_done;
   end
   // Watchdog
   initial begin
      tick(20000);
      failures++;
      test_done;
   end
endmodule : mmt_timer_bench
`default_nettype wire
